// file: inc/dcd_defines.svh
// Offsets, field positions, reset values and layout of the descriptor engine
`ifndef DCD_DEFINES_SVH
`define DCD_DEFINES_SVH

// ==========================================================================
// APB register byte offsets
`define DCD_OFF_CTRL 12'h000
`define DCD_OFF_DPTR 12'h004
`define DCD_OFF_STOP 12'h008
`define DCD_OFF_STAT 12'h00c
`define DCD_OFF_CUR 12'h010

// Control register fields
`define DCD_CTRL_GO 0
`define DCD_CTRL_RX 1
`define DCD_CTRL_SWAP 2
// Status register fields
`define DCD_STAT_BUSY 0
`define DCD_STAT_DONE 1

// ==========================================================================
// Descriptor byte offsets from the even base address
`define DCD_B_LINK_LO 4'h0
`define DCD_B_LINK_HI 4'h1
`define DCD_B_ADDR_LO 4'h2
`define DCD_B_ADDR_MID 4'h3
`define DCD_B_ADDR_BANK 4'h4
`define DCD_B_RSV_A 4'h5
`define DCD_B_CNT_LO 4'h6
`define DCD_B_CNT_HI 4'h7
`define DCD_B_STATUS 4'h8
`define DCD_B_RSV_B 4'h9

// Status byte bit positions
`define DCD_STS_FRAME_END 7
`define DCD_STS_SHORT 6
`define DCD_STS_ABORT 5
`define DCD_STS_RESIDUAL 4
`define DCD_STS_OVERRUN 3
`define DCD_STS_CRC 2
`define DCD_STS_CHAIN_END 0
// Receive status bits 1 and 0 never carry information
`define DCD_RX_STS_MASK 8'hfc

// Reset values
`define DCD_RST_BYTE 8'h00
`define DCD_RST_HALF 16'h0000

`endif

// file: inc/dcd_pkg.sv
// Types shared by the descriptor engine files
`default_nettype none
`include "dcd_defines.svh"

package dcd_pkg;

    // ======================================================================
    // Engine sequence
    typedef enum logic [2:0] {
        DCD_IDLE,
        DCD_RD_SET,
        DCD_RD_WAIT,
        DCD_BUF,
        DCD_WR_SET,
        DCD_WR_WAIT
    } dcd_state_t;

    // Whole state of the engine
    typedef struct packed {
        dcd_state_t fsm;
        logic ctl_rx;
        logic ctl_swap;
        logic [7:0] bank;
        logic [15:0] first;
        logic [15:0] stop;
        logic [15:0] ptr;
        logic [15:0] link;
        logic [23:0] baddr;
        logic [15:0] cnt;
        logic [7:0] stat;
        logic [3:0] idx;
        logic req;
        logic we;
        logic [23:0] maddr;
        logic [7:0] wdata;
        logic done;
    } dcd_regs_t;

endpackage : dcd_pkg

`default_nettype wire

// file: core/dcd_lane_map.sv
// Descriptor byte lane mapping for the two bus mode groups
`default_nettype none
`include "dcd_defines.svh"

module dcd_lane_map
    import dcd_pkg::*;
(
    input wire logic [3:0] i_idx,
    input wire logic i_swap,
    output logic [3:0] o_off
);

    // ======================================================================
    // Lane swap
    // pair swap
    // Swapping the low address bit exchanges each even/odd byte pair
    generate
        for (genvar b = 0; b < 4; b++)
        begin : g_bit
            if (b == 0)
            begin : g_lsb
                assign o_off[b] = i_idx[b] ^ i_swap;
            end
            else
            begin : g_pass
                assign o_off[b] = i_idx[b];
            end
        end
    endgenerate

endmodule : dcd_lane_map

`default_nettype wire

// file: core/dcd_engine.sv
// Chained-descriptor DMA engine with APB control registers
//
// Design decisions made here: the register addresses and register access over APB.
`default_nettype none
`include "dcd_defines.svh"

// Operation
// - Descriptor starts at even address with 16-bit link, low byte first.
// - 24-bit buffer address at bytes 2,3,4; byte 5 is reserved.
// - Byte count at 6 and 7, status at 8, byte 9 reserved.
// - Second mode group swaps every even/odd byte pair of the descriptor.
// - Transmit status bit 7 is frame end, bit 0 is chain end.
// - Receive status sets bit 7 frame end, 6 short, 5 abort.
// - Receive status sets bit 4 residual, 3 overrun, 2 CRC; 1,0 zero.
module dcd_engine
    import dcd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_mem_req,
    output logic o_mem_we,
    output logic [23:0] o_mem_addr,
    output logic [7:0] o_mem_wdata,
    input wire logic i_mem_ack,
    input wire logic [7:0] i_mem_rdata,
    output logic o_buf_valid,
    output logic [23:0] o_buf_addr,
    output logic [15:0] o_buf_count,
    output logic o_buf_frame_end,
    input wire logic i_buf_done,
    input wire logic [15:0] i_rx_count,
    input wire logic [7:0] i_rx_status,
    output logic o_busy
);

    dcd_regs_t q;
    dcd_regs_t d;
    logic [3:0] lane_off;
    logic apb_acc;
    logic apb_wr;
    logic hit_ctrl;
    logic hit_dptr;
    logic hit_stop;
    logic hit_stat;
    logic hit_cur;

    // ======================================================================
    // Byte lane mapping
    dcd_lane_map u_lane (
        .i_idx(q.idx),
        .i_swap(q.ctl_swap),
        .o_off(lane_off)
    );

    // ======================================================================
    // APB decode; zero wait states, unmapped words flag an error
    assign apb_acc = i_psel && i_penable;
    assign apb_wr = apb_acc && i_pwrite;
    assign hit_ctrl = (i_paddr == `DCD_OFF_CTRL);
    assign hit_dptr = (i_paddr == `DCD_OFF_DPTR);
    assign hit_stop = (i_paddr == `DCD_OFF_STOP);
    assign hit_stat = (i_paddr == `DCD_OFF_STAT);
    assign hit_cur = (i_paddr == `DCD_OFF_CUR);
    assign o_pready = 1'b1;
    assign o_pslverr = apb_acc
        && !(hit_ctrl || hit_dptr || hit_stop || hit_stat || hit_cur);

    // Read mux, all sources are flops
    always_comb
    begin
        o_prdata = 32'h0000_0000;
        if (hit_ctrl)
        begin
            o_prdata[`DCD_CTRL_RX] = q.ctl_rx;
            o_prdata[`DCD_CTRL_SWAP] = q.ctl_swap;
        end
        else if (hit_dptr)
        begin
            o_prdata[23:0] = {q.bank, q.first};
        end
        else if (hit_stop)
        begin
            o_prdata[15:0] = q.stop;
        end
        else if (hit_stat)
        begin
            o_prdata[`DCD_STAT_BUSY] = (q.fsm != DCD_IDLE);
            o_prdata[`DCD_STAT_DONE] = q.done;
            o_prdata[15:8] = q.stat;
        end
        else if (hit_cur)
        begin
            o_prdata[15:0] = q.ptr;
        end
    end

    // ======================================================================
    // Next state
    always_comb
    begin
        d = q;
        // Software clear of done; a later set in this process wins
        if (apb_wr && hit_stat && i_pwdata[`DCD_STAT_DONE])
        begin
            d.done = 1'b0;
        end
        // Mode bits only change while idle, to keep a chain consistent
        if (apb_wr && hit_ctrl && q.fsm == DCD_IDLE)
        begin
            d.ctl_rx = i_pwdata[`DCD_CTRL_RX];
            d.ctl_swap = i_pwdata[`DCD_CTRL_SWAP];
        end
        if (apb_wr && hit_dptr)
        begin
            d.first = i_pwdata[15:0];
            d.bank = i_pwdata[23:16];
        end
        if (apb_wr && hit_stop)
        begin
            d.stop = i_pwdata[15:0];
        end
        case (q.fsm)
            DCD_IDLE:
            begin
                if (apb_wr && hit_ctrl && i_pwdata[`DCD_CTRL_GO])
                begin
                    d.ptr = q.first;
                    d.idx = `DCD_B_LINK_LO;
                    d.fsm = DCD_RD_SET;
                end
            end
            DCD_RD_SET:
            begin
                d.maddr = {q.bank, q.ptr} + {20'h00000, lane_off};
                d.req = 1'b1;
                d.we = 1'b0;
                d.fsm = DCD_RD_WAIT;
            end
            DCD_RD_WAIT:
            begin
                if (i_mem_ack)
                begin
                    d.req = 1'b0;
                    d.idx = q.idx + 4'h1;
                    d.fsm = DCD_RD_SET;
                    case (q.idx)
                        `DCD_B_LINK_LO: d.link[7:0] = i_mem_rdata;
                        `DCD_B_LINK_HI: d.link[15:8] = i_mem_rdata;
                        `DCD_B_ADDR_LO: d.baddr[7:0] = i_mem_rdata;
                        `DCD_B_ADDR_MID: d.baddr[15:8] = i_mem_rdata;
                        `DCD_B_ADDR_BANK:
                        begin
                            d.baddr[23:16] = i_mem_rdata;
                            d.idx = `DCD_B_CNT_LO;
                        end
                        // count and status, last byte fetched
                        `DCD_B_CNT_LO: d.cnt[7:0] = i_mem_rdata;
                        `DCD_B_CNT_HI: d.cnt[15:8] = i_mem_rdata;
                        `DCD_B_STATUS:
                        begin
                            d.stat = i_mem_rdata;
                            d.fsm = DCD_BUF;
                        end
                        default: d.fsm = DCD_IDLE;
                    endcase
                end
            end
            DCD_BUF:
            begin
                if (i_buf_done)
                begin
                    if (q.ctl_rx)
                    begin
                        // receive flags, unused bits forced low
                        d.stat = i_rx_status & `DCD_RX_STS_MASK;
                        d.cnt = i_rx_count;
                        d.idx = `DCD_B_CNT_LO;
                        d.fsm = DCD_WR_SET;
                    end
                    else if (q.stat[`DCD_STS_CHAIN_END])
                    begin
                        d.fsm = DCD_IDLE;
                        d.done = 1'b1;
                    end
                    else
                    begin
                        d.ptr = q.link;
                        d.idx = `DCD_B_LINK_LO;
                        d.fsm = DCD_RD_SET;
                    end
                end
            end
            DCD_WR_SET:
            begin
                d.maddr = {q.bank, q.ptr} + {20'h00000, lane_off};
                d.req = 1'b1;
                d.we = 1'b1;
                d.fsm = DCD_WR_WAIT;
                case (q.idx)
                    `DCD_B_CNT_LO: d.wdata = q.cnt[7:0];
                    `DCD_B_CNT_HI: d.wdata = q.cnt[15:8];
                    default: d.wdata = q.stat;
                endcase
            end
            DCD_WR_WAIT:
            begin
                if (i_mem_ack)
                begin
                    d.req = 1'b0;
                    d.we = 1'b0;
                    if (q.idx != `DCD_B_STATUS)
                    begin
                        d.idx = q.idx + 4'h1;
                        d.fsm = DCD_WR_SET;
                    end
                    // link followed only after status is written
                    else if (q.link == q.stop)
                    begin
                        d.fsm = DCD_IDLE;
                        d.done = 1'b1;
                    end
                    else
                    begin
                        d.ptr = q.link;
                        d.idx = `DCD_B_LINK_LO;
                        d.fsm = DCD_RD_SET;
                    end
                end
            end
            default: d.fsm = DCD_IDLE;
        endcase
    end

    // ======================================================================
    // State register, frozen while the clock enable is low
    always_ff @(posedge i_clk or posedge i_reset)
    begin
        if (i_reset)
        begin
            q <= '0;
        end
        else if (i_ce)
        begin
            q <= d;
        end
    end

    // Outputs
    assign o_mem_req = q.req;
    assign o_mem_we = q.we;
    assign o_mem_addr = q.maddr;
    assign o_mem_wdata = q.wdata;
    assign o_buf_valid = (q.fsm == DCD_BUF);
    assign o_buf_addr = q.baddr;
    assign o_buf_count = q.cnt;
    // frame end from the status byte
    assign o_buf_frame_end = q.stat[`DCD_STS_FRAME_END];
    assign o_busy = (q.fsm != DCD_IDLE);

    // ======================================================================
    // Assertions
    sequence s_rx_close;
        o_buf_valid && q.ctl_rx && i_buf_done && i_ce;
    endsequence

    sequence s_status_wb;
        o_mem_req && o_mem_we && q.idx == `DCD_B_STATUS && i_mem_ack;
    endsequence

    a_req_hold_stable: assert property (
        @(posedge i_clk) disable iff (i_reset || !i_ce)
        o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
        else $error("memory request dropped or moved before ack");

    a_lane_parity: assert property (
        @(posedge i_clk) disable iff (i_reset)
        o_mem_req && !q.ptr[0] |-> o_mem_addr[0] == (q.ctl_swap ^ q.idx[0]))
        else $error("descriptor byte on wrong lane");

    a_reserved_skip: assert property (
        @(posedge i_clk) disable iff (i_reset)
        o_mem_req |-> q.idx != `DCD_B_RSV_A && q.idx != `DCD_B_RSV_B)
        else $error("reserved descriptor byte accessed");

    a_rx_unused_zero: assert property (
        @(posedge i_clk) disable iff (i_reset)
        o_mem_req && o_mem_we && q.idx == `DCD_B_STATUS
        |-> o_mem_wdata[1:0] == 2'b00)
        else $error("receive status bits 1:0 not zero");

    a_count_wb: assert property (
        @(posedge i_clk) disable iff (i_reset)
        o_mem_req && o_mem_we && q.idx == `DCD_B_CNT_HI
        |-> o_mem_wdata == q.cnt[15:8])
        else $error("count high byte written wrong");

    a_wb_before_link: assert property (
        @(posedge i_clk) disable iff (i_reset || !i_ce)
        s_rx_close |=> (!o_mem_req || o_mem_we)
            throughout (##[1:1000] s_status_wb))
        else $error("status write-back missing after close");

    a_tx_chain_stop: assert property (
        @(posedge i_clk) disable iff (i_reset || !i_ce)
        o_buf_valid && !q.ctl_rx && i_buf_done
        && q.stat[`DCD_STS_CHAIN_END] |=> !o_busy ##1 !o_busy)
        else $error("transmit chain did not stop at chain end");

    a_rx_flags_kept: assert property (
        @(posedge i_clk) disable iff (i_reset || !i_ce)
        s_rx_close |=> q.stat[7:5] == $past(i_rx_status[7:5]))
        else $error("receive frame flags not captured");

endmodule : dcd_engine

`default_nettype wire

// file: tb/dcd_mem_model.sv
// Byte-wide shared memory model that answers the engine's requests
`default_nettype none

module dcd_mem_model
(
    input wire logic i_clk,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic [23:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [1:0] i_delay,
    output logic o_ack,
    output logic [7:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem [0:1023];
    logic [1:0] wait_q = 2'h0;

    initial o_ack = 1'b0;
    initial o_rdata = 8'h00;

    // ======================================================================
    // Request service
    // layout kept as software stored it, bank not decoded
    always @(posedge i_clk)
    begin
        o_ack <= 1'b0;
        if (i_req && !o_ack && wait_q == 2'h0)
        begin
            o_ack <= 1'b1;
            o_rdata <= mem[i_addr[9:0]];
            if (i_we)
                mem[i_addr[9:0]] <= i_wdata;
            wait_q <= i_delay;
        end
        else
        begin
            if (i_req && !o_ack)
                wait_q <= wait_q - 2'h1;
            // Data outside an answer is junk, not the last byte
            o_rdata <= ~o_rdata;
        end
    end
endmodule : dcd_mem_model

`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the chained-descriptor engine
`default_nettype none
`include "dcd_defines.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_clk = 0, i_reset = 1, i_ce = 1, i_psel = 0, i_penable = 0;
    logic i_pwrite = 0, i_buf_done = 0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, rd;
    logic [15:0] i_rx_count = 16'h0;
    logic [7:0] i_rx_status = 8'h00, last_sb;
    logic [1:0] i_delay = 2'h0;
    wire logic [31:0] o_prdata;
    wire logic [23:0] mem_addr, o_buf_addr;
    wire logic [15:0] o_buf_count;
    wire logic [7:0] mem_wdata, mem_rdata;
    wire logic o_pready, o_pslverr, mem_req, mem_we, mem_ack;
    wire logic o_buf_valid, o_buf_frame_end, o_busy;
    logic err;
    logic [40:0] e;
    logic [23:0] w;
    logic [40:0] exp_q [$];
    logic [23:0] rxw_q [$];
    integer err_count = 0, samples_checked = 0, cyc = 0;
    integer seed = 32'h8b0e5d1a;

    dcd_engine u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .o_mem_req(mem_req),
        .o_mem_we(mem_we), .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata),
        .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata),
        .o_buf_valid(o_buf_valid), .o_buf_addr(o_buf_addr),
        .o_buf_count(o_buf_count), .o_buf_frame_end(o_buf_frame_end),
        .i_buf_done(i_buf_done), .i_rx_count(i_rx_count),
        .i_rx_status(i_rx_status), .o_busy(o_busy));

    dcd_mem_model u_mem (.i_clk(i_clk), .i_req(mem_req), .i_we(mem_we),
        .i_addr(mem_addr), .i_wdata(mem_wdata), .i_delay(i_delay),
        .o_ack(mem_ack), .o_rdata(mem_rdata));

    // ======================================================================
    // Checking and verdict
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
        samples_checked++;
        if (seen !== x)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, x, seen);
        end
    endtask : chk

    task stop_test;
        if (err_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    // ======================================================================
    // APB master, request held until pready sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (o_pready !== 1'b1 && n < 50);
        // A slave that never answers counts as a mismatch
        if (o_pready !== 1'b1)
            err_count++;
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    // Descriptor image, pairs swapped in the second mode group
    task put(input int b, input logic [15:0] lk, input logic [23:0] ba,
        input logic [15:0] c, input logic [7:0] sb, input int sw);
        logic [7:0] v [10];
        v = '{lk[7:0], lk[15:8], ba[7:0], ba[15:8], ba[23:16], 8'h5a,
            c[7:0], c[15:8], sb, 8'ha5};
        for (int i = 0; i < 10; i++)
            u_mem.mem[b + (i ^ sw)] = v[i];
    endtask : put

    // One whole chain, then done flag checked, and receive write-back for rx runs
    task run(input logic rx, input int sw, input int n);
        logic [23:0] ba;
        logic [15:0] c, stop;
        logic [7:0] sb;
        int b;
        stop = 16'h0300 + 16'(n);
        rxw_q.delete();
        i_delay <= 2'($random(seed));
        for (int i = 0; i < n; i++)
        begin
            b = 'h100 + 'h20 * i;
            ba = 24'($random(seed));
            c = 16'($random(seed));
            sb = 8'($random(seed)) & 8'hfe;
            if (!rx && i == n - 1)
                sb[0] = 1'b1;
            put(b, (i == n - 1) ? stop : 16'(b + 'h20), ba, c, sb, sw);
            exp_q.push_back({sb[7], c, ba});
        end
        apb(1'b1, `DCD_OFF_DPTR, 32'h003c_0100);
        apb(1'b1, `DCD_OFF_STOP, {16'h0, stop});
        apb(1'b1, `DCD_OFF_CTRL, {29'h0, sw[0], rx, 1'b1});
        for (int k = 0; k < 300; k++)
        begin
            apb(1'b0, `DCD_OFF_STAT, 32'h0);
            if (rd[1] === 1'b1)
                break;
        end
        chk("stat_done", rd[1:0], 2'b10);
        chk("queue_left", exp_q.size(), 0);
        if (rx)
        begin
            chk("last_status", rd[15:8], last_sb & 8'hfc);
            for (int i = 0; i < n; i++)
            begin
                b = 'h100 + 'h20 * i;
                w = rxw_q.pop_front();
                chk("rx_count", {u_mem.mem[b + (7 ^ sw)],
                    u_mem.mem[b + (6 ^ sw)]}, w[23:8]);
                chk("rx_status", u_mem.mem[b + (8 ^ sw)],
                    w[7:0] & 8'hfc);
            end
        end
        // Engine parked on the last descriptor, base and bank untouched
        chk("busy_low", o_busy, 1'b0);
        apb(1'b0, `DCD_OFF_CUR, 32'h0);
        chk("cur_ptr", rd, 32'h100 + 32'h20 * (n - 1));
        apb(1'b0, `DCD_OFF_DPTR, 32'h0);
        chk("dptr_back", rd, 32'h003c_0100);
        apb(1'b1, `DCD_OFF_STAT, 32'h2);
        apb(1'b0, `DCD_OFF_STAT, 32'h0);
        chk("done_clear", rd[1], 1'b0);
    endtask : run

    // ======================================================================
    // Clock, timeout and bank watch
    initial
        forever #10 i_clk = ~i_clk;

    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (mem_req === 1'b1)
            chk("desc_bank", mem_addr[23:16], 8'h3c);
        if (cyc > 20000)
        begin
            err_count++;
            stop_test();
        end
    end

    // Buffer side: compare oldest note, then finish with random rx result
    initial
        forever
        begin
            // Looked at mid-cycle, where the outputs have settled
            @(negedge i_clk);
            if (o_buf_valid === 1'b1)
            begin
                e = (exp_q.size() > 0) ? exp_q.pop_front() : 41'h0;
                chk("buf_addr", o_buf_addr, e[23:0]);
                chk("buf_count", o_buf_count, e[39:24]);
                chk("frame_end", o_buf_frame_end, e[40]);
                repeat (2) @(posedge i_clk);
                w = {16'($random(seed)), 8'($random(seed))};
                last_sb = w[7:0];
                rxw_q.push_back(w);
                i_buf_done <= 1'b1;
                i_rx_count <= w[23:8];
                i_rx_status <= w[7:0];
                @(posedge i_clk);
                i_buf_done <= 1'b0;
            end
        end

    // ======================================================================
    // Main sequence
    initial
    begin
        repeat (16) @(posedge i_clk);
        i_reset <= 1'b0;
        apb(1'b0, 12'h014, 32'h0);
        chk("unmapped_err", err, 1'b1);
        chk("unmapped_data", rd, 32'h0);
        apb(1'b0, `DCD_OFF_CTRL, 32'h0);
        chk("ctrl_reset", rd, 32'h0);
        chk("mapped_err", err, 1'b0);
        // Clock enable low: the write must be lost, then a real one lands
        w = 24'($random(seed));
        i_ce <= 1'b0;
        apb(1'b1, `DCD_OFF_STOP, {16'h0, w[15:0]});
        i_ce <= 1'b1;
        apb(1'b0, `DCD_OFF_STOP, 32'h0);
        chk("stop_frozen", rd, 32'h0);
        apb(1'b1, `DCD_OFF_STOP, {16'h0, w[15:0]});
        apb(1'b0, `DCD_OFF_STOP, 32'h0);
        chk("stop_kept", rd, {16'h0, w[15:0]});
        run(1'b0, 0, 2);
        run(1'b0, 1, 2);
        run(1'b1, 0, 3);
        run(1'b1, 1, 2);
        stop_test();
    end
endmodule : tb_top

`default_nettype wire
